// ### inc/pll_clock_map.vh
/*
 Register offsets, field positions, reset values and counts for the
 PLL base clock selector. Assumes byte addressing on a 32-bit AXI4-Lite bus.
*/
`ifndef PLL_CLOCK_MAP_VH
`define PLL_CLOCK_MAP_VH

// ***********************
// Register byte offsets
// ***********************
`define OFS_PLL_CONTROL 5'h00
`define OFS_BANDWIDTH_CONTROL 5'h04
`define OFS_VCO_RANGE 5'h08
`define OFS_REF_DIVIDER 5'h0C
`define OFS_MULTIPLIER 5'h10

// ***********************
// Control register fields
// ***********************
`define BIT_INT_ENABLE 7
`define BIT_INT_FLAG 6
`define BIT_PLL_ENABLE 5
`define BIT_BASE_SELECT 4
`define BIT_PRESCALER_HI 3
`define BIT_PRESCALER_LO 2
`define BIT_RANGE_HI 1
`define BIT_RANGE_LO 0

// ***********************
// Bandwidth register fields
// ***********************
`define BIT_AUTO_BW 0
`define BIT_SETTLED 1

// ***********************
// Reset values
// ***********************
`define RST_VCO_RANGE 8'h40
`define RST_REF_DIVIDER 4'h1
`define RST_MULTIPLIER 12'h040

// ***********************
// Transition and bus codes
// ***********************
`define TRANS_EDGES 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/pll_base_clock_selector.v
/*
 PLL control register file and glitch-free base clock selector.
 Assumes osc_clock, divided_vco_clock and vcoLock are synchronous inputs
 sampled by sys_clk, and both sources run well below sys_clk / 2.
*/
// Local design decisions: the AXI4-Lite register port and the register addresses.
// Summary of operation
// (R1) Reference divider or multiplier of zero acts exactly like one.
// (R2) Zero VCO range disables the PLL and blocks VCO selection.
// (R3) Source change waits three old and three new edges, output held.
// (R4) Transition output is divided by two for 50 percent duty.
// (R5) Select one drives VCO clock halved, zero drives oscillator halved.
// (R6) Base select cannot be set while PLL is off.
// (R7) PLL cannot be switched off while base select is one.
// (R8) One write cannot both switch PLL and change base select.
// (R9) Interrupt enable refuses writes and reads zero in manual mode; reset clears.
// (R10) Flag sets on every settled change; interrupt when flag and enable.
// (R11) Flag reads zero in manual bandwidth mode.
// (R12) Any control register read clears the flag; reset clears it.
// (R13) Reset turns PLL on and selects the oscillator clock.
// (R14) Prescaler bits pick 1,2,4,8; locked while PLL on; reset clears.
// (R15) Range bits pick 1,2,4; locked while PLL on; reset clears.
// (R16) Software never programs range value three.
// (R17) Base clock output is 50 percent duty at half the selected source rate.
// (R18) Reference clock is a buffered copy of the oscillator clock.
// (R19) Auto bandwidth bit is read/write, reset clears, one means automatic.
// (R20) Settled flag shows lock in automatic mode, reads zero otherwise.
// (R21) Writing zero range disables PLL and clears base select; VCO range writes are ignored while PLL enable is set.
// (R22) Each source passes a synchroniser so no runt pulse appears.
// (R23) A lock change in the clearing read cycle keeps the flag set.
`timescale 1ns/1ps
`include "pll_clock_map.vh"

module pll_base_clock_selector (
   input wire sys_clk,
   input wire rst,
   input wire osc_clock,
   input wire divided_vco_clock,
   input wire vcoLock,
   output wire ref_clock,
   output reg base_clock_out,
   output wire pll_interrupt,
   output wire pllPowerOn,
   output wire [1:0] prescalerCode,
   output wire [1:0] vcoPowerCode,
   output wire [7:0] vcoRangeValue,
   output wire [3:0] refDivEffective,
   output wire [11:0] multEffective,
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   localparam ST_RUN = 1'b0;
   localparam ST_SWITCH = 1'b1;

   reg pll_int_enable;
   reg pll_int_flag;
   reg pll_enable;
   reg base_clock_select;
   reg [1:0] prescaler_bits;
   reg [1:0] vco_power_range_bits;
   reg auto_bw_select;
   reg [7:0] vco_range_reg;
   reg [3:0] refDivider;
   reg [11:0] multiplier;
   reg lockSample;
   reg settledLast;
   reg [2:0] oscSync;
   reg [2:0] vcoSync;
   reg state;
   reg activeSelect;
   reg [1:0] oldEdges;
   reg [1:0] newEdges;

   wire freq_settled_flag;
   wire settledChange;
   wire oscEdge;
   wire vcoEdge;
   wire oldEdge;
   wire newEdge;
   wire wrFire;
   wire rdFire;
   wire wrLane0;
   wire [7:0] wByte;
   wire pllChangeReq;
   wire rangeZero;
   wire ctlRead;

   // ***********************
   // Bus handshakes
   // ***********************
   assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_wready = s_axi_awready;
   assign wrFire = s_axi_awready;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rdFire = s_axi_arvalid & s_axi_arready;
   assign wrLane0 = wrFire & s_axi_wstrb[0];
   assign wByte = s_axi_wdata[7:0];
   assign ctlRead = rdFire & (s_axi_araddr[4:2] == `OFS_PLL_CONTROL >> 2);

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         if (s_axi_awaddr[4:2] > (`OFS_MULTIPLIER >> 2))
            s_axi_bresp <= `RESP_SLVERR;
         else
            s_axi_bresp <= `RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ***********************
   // Status inputs
   // ***********************
   assign freq_settled_flag = auto_bw_select & lockSample; // R20
   assign settledChange = freq_settled_flag != settledLast;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lockSample <= 1'b0;
         settledLast <= 1'b0;
      end else begin
         lockSample <= vcoLock;
         settledLast <= freq_settled_flag;
      end
   end

   // ***********************
   // Control register writes
   // ***********************
   assign rangeZero = vco_range_reg == 8'h00;
   assign pllChangeReq = wByte[`BIT_PLL_ENABLE] != pll_enable;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pll_int_enable <= 1'b0; // R9
         pll_enable <= 1'b1; // R13
         base_clock_select <= 1'b0; // R13
         prescaler_bits <= 2'h0; // R14
         vco_power_range_bits <= 2'h0; // R15
      end else begin
         if (!auto_bw_select)
            pll_int_enable <= 1'b0; // R9
         else if (wrLane0 && s_axi_awaddr[4:2] == (`OFS_PLL_CONTROL >> 2))
            pll_int_enable <= wByte[`BIT_INT_ENABLE];
         if (wrLane0 && s_axi_awaddr[4:2] == (`OFS_PLL_CONTROL >> 2)) begin
            if (pllChangeReq && !(pll_enable && base_clock_select)) // R7
               pll_enable <= wByte[`BIT_PLL_ENABLE];
            if (!pllChangeReq) begin // R8
               if (!wByte[`BIT_BASE_SELECT])
                  base_clock_select <= 1'b0;
               else if (pll_enable && !rangeZero) // R6 R2
                  base_clock_select <= 1'b1;
            end
            if (!pll_enable) begin
               prescaler_bits <= wByte[`BIT_PRESCALER_HI:`BIT_PRESCALER_LO]; // R14
               vco_power_range_bits <= wByte[`BIT_RANGE_HI:`BIT_RANGE_LO]; // R15
            end
         end
         if (rangeZero)
            base_clock_select <= 1'b0; // R21
      end
   end

   // ***********************
   // Lock change flag
   // ***********************
   always @(posedge sys_clk or posedge rst) begin
      if (rst)
         pll_int_flag <= 1'b0; // R12
      else if (!auto_bw_select)
         pll_int_flag <= 1'b0; // R11
      else if (settledChange)
         pll_int_flag <= 1'b1; // R10 R23
      else if (ctlRead)
         pll_int_flag <= 1'b0; // R12
   end

   assign pll_interrupt = pll_int_flag & pll_int_enable; // R10

   // ***********************
   // Other registers
   // ***********************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         auto_bw_select <= 1'b0; // R19
         vco_range_reg <= `RST_VCO_RANGE;
         refDivider <= `RST_REF_DIVIDER;
         multiplier <= `RST_MULTIPLIER;
      end else if (wrFire) begin
         case (s_axi_awaddr[4:2])
            (`OFS_BANDWIDTH_CONTROL >> 2): begin
               if (s_axi_wstrb[0])
                  auto_bw_select <= wByte[`BIT_AUTO_BW]; // R19
            end
            (`OFS_VCO_RANGE >> 2): begin
               if (s_axi_wstrb[0] && !pll_enable)
                  vco_range_reg <= wByte; // R21
            end
            (`OFS_REF_DIVIDER >> 2): begin
               if (s_axi_wstrb[0] && !pll_enable)
                  refDivider <= wByte[3:0];
            end
            (`OFS_MULTIPLIER >> 2): begin
               if (!pll_enable) begin
                  if (s_axi_wstrb[0])
                     multiplier[7:0] <= wByte;
                  if (s_axi_wstrb[1])
                     multiplier[11:8] <= s_axi_wdata[11:8];
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign refDivEffective = (refDivider == 4'h0) ? 4'h1 : refDivider; // R1
   assign multEffective = (multiplier == 12'h000) ? 12'h001 : multiplier; // R1
   assign pllPowerOn = pll_enable & ~rangeZero; // R2
   assign prescalerCode = prescaler_bits;
   assign vcoPowerCode = vco_power_range_bits;
   assign vcoRangeValue = vco_range_reg;
   assign ref_clock = osc_clock; // R18

   // ***********************
   // Register reads
   // ***********************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (rdFire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
         case (s_axi_araddr[4:2])
            (`OFS_PLL_CONTROL >> 2):
               s_axi_rdata[7:0] <= {pll_int_enable, pll_int_flag & auto_bw_select, // R9 R11
                                    pll_enable, base_clock_select, prescaler_bits, vco_power_range_bits};
            (`OFS_BANDWIDTH_CONTROL >> 2): begin
               s_axi_rdata[`BIT_AUTO_BW] <= auto_bw_select;
               s_axi_rdata[`BIT_SETTLED] <= freq_settled_flag; // R20
            end
            (`OFS_VCO_RANGE >> 2):
               s_axi_rdata[7:0] <= vco_range_reg;
            (`OFS_REF_DIVIDER >> 2):
               s_axi_rdata[3:0] <= refDivider;
            (`OFS_MULTIPLIER >> 2):
               s_axi_rdata[11:0] <= multiplier;
            default:
               s_axi_rresp <= `RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ***********************
   // Source synchronisers
   // ***********************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         oscSync <= 3'h0;
         vcoSync <= 3'h0;
      end else begin
         oscSync <= {oscSync[1:0], osc_clock}; // R22
         vcoSync <= {vcoSync[1:0], divided_vco_clock}; // R22
      end
   end

   assign oscEdge = oscSync[1] & ~oscSync[2];
   assign vcoEdge = vcoSync[1] & ~vcoSync[2];
   assign oldEdge = activeSelect ? vcoEdge : oscEdge;
   assign newEdge = activeSelect ? oscEdge : vcoEdge;

   // ***********************
   // Transition control and halving
   // ***********************
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= ST_RUN;
         activeSelect <= 1'b0;
         oldEdges <= 2'h0;
         newEdges <= 2'h0;
         base_clock_out <= 1'b0;
      end else begin
         case (state)
            ST_RUN: begin
               if (base_clock_select != activeSelect) begin
                  state <= ST_SWITCH; // R3
                  oldEdges <= 2'h0;
                  newEdges <= 2'h0;
               end else if (oldEdge) begin
                  base_clock_out <= ~base_clock_out; // R4 R5 R17
               end
            end
            ST_SWITCH: begin
               if (oldEdge && oldEdges != `TRANS_EDGES)
                  oldEdges <= oldEdges + 2'h1; // R3
               if (newEdge && newEdges != `TRANS_EDGES)
                  newEdges <= newEdges + 2'h1; // R3
               if (oldEdges == `TRANS_EDGES && newEdges == `TRANS_EDGES) begin
                  activeSelect <= ~activeSelect; // R5
                  state <= ST_RUN;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

endmodule

// ### sim/pll_base_clock_selector_assertions.sv
/*
 Port-level checker for the PLL base clock selector.
 Assumes a single sys_clk domain with rst active high.
*/
`timescale 1ns/1ps
// ***********************
// Checker
// ***********************
module pll_base_clock_selector_assertions (
   input wire sys_clk,
   input wire rst,
   input wire osc_clock,
   input wire ref_clock,
   input wire pllPowerOn,
   input wire [1:0] prescalerCode,
   input wire [1:0] vcoPowerCode,
   input wire [7:0] vcoRangeValue,
   input wire [3:0] refDivEffective,
   input wire [11:0] multEffective,
   input wire s_axi_awvalid,
   input wire s_axi_wvalid,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_ref_copy: assert property (ref_clock == osc_clock)
      else $error("reference clock differs from oscillator");
   a_div_nonzero: assert property (refDivEffective != 4'h0 && multEffective != 12'h000)
      else $error("effective divider or multiplier is zero");
   a_range_zero: assert property (vcoRangeValue == 8'h00 |-> !pllPowerOn)
      else $error("PLL powered with zero range");
   a_codes_locked: assert property (pllPowerOn |=> $stable(prescalerCode) && $stable(vcoPowerCode))
      else $error("codes changed while PLL on");
   a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
      else $error("write not answered next cycle");
   a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_unmapped_err: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr[4:2] > 3'h4
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind pll_base_clock_selector pll_base_clock_selector_assertions chk (.*);

// ### sim/base_clock_consumer.sv
/*
 Far-side model: makes the two source clocks and measures the level
 lengths of the base clock in sys_clk cycles. Assumes sys_clk runs.
*/
`timescale 1ns/1ps
module base_clock_consumer #(parameter OSC_HALF = 4, parameter VCO_HALF = 6) (
   input wire sys_clk,
   input wire rst,
   input wire base_clock_out,
   output reg osc_clock,
   output reg divided_vco_clock,
   output reg [7:0] highLen,
   output reg [7:0] lowLen
);
   reg [7:0] oscCnt, vcoCnt, runLen;
   reg lastBase;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {oscCnt, vcoCnt, runLen, highLen, lowLen} <= 40'h0;
         {osc_clock, divided_vco_clock, lastBase} <= 3'h0;
      end else begin
         oscCnt <= (oscCnt == OSC_HALF - 1) ? 8'h00 : oscCnt + 8'h01;
         vcoCnt <= (vcoCnt == VCO_HALF - 1) ? 8'h00 : vcoCnt + 8'h01;
         if (oscCnt == OSC_HALF - 1) osc_clock <= ~osc_clock;
         if (vcoCnt == VCO_HALF - 1) divided_vco_clock <= ~divided_vco_clock;
         lastBase <= base_clock_out;
         // Level lengths give period and duty of the base clock
         if (base_clock_out != lastBase) begin
            runLen <= 8'h01;
            if (lastBase) highLen <= runLen;
            else lowLen <= runLen;
         end else runLen <= runLen + 8'h01;
      end
   end
endmodule

// ### sim/pll_base_clock_selector_tb.sv
/*
 Register-level testbench for the PLL base clock selector.
 Assumes the consumer model makes sources of 8 and 12 sys_clk periods.
*/
`timescale 1ns/1ps
`include "pll_clock_map.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module pll_base_clock_selector_tb;
   reg sys_clk, rst, vcoLock, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg [4:0] s_axi_awaddr, s_axi_araddr;
   reg [31:0] s_axi_wdata, rdv;
   reg [1:0] resp;
   wire [3:0] s_axi_wstrb = 4'hF;
   wire osc_clock, divided_vco_clock, ref_clock, base_clock_out, pll_interrupt, pllPowerOn;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] prescalerCode, vcoPowerCode, s_axi_bresp, s_axi_rresp;
   wire [7:0] vcoRangeValue, highLen, lowLen;
   wire [3:0] refDivEffective;
   wire [11:0] multEffective;
   wire [31:0] s_axi_rdata;
   integer failures = 0, n_compared = 0;
   localparam [4:0] CTL = `OFS_PLL_CONTROL;
   pll_base_clock_selector uut (.*);
   base_clock_consumer far (.*);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // ***********************
   // Bus tasks
   // ***********************
   task wr(input [4:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
         #1 while (!s_axi_awready) begin @(posedge sys_clk); #1; end
         @(posedge sys_clk);
         {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
         #1 while (s_axi_bvalid !== 1'b1) begin @(posedge sys_clk); #1; end
         @(posedge sys_clk);
         resp = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [4:0] a);
      begin
         @(posedge sys_clk);
         {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
         #1 while (!s_axi_arready) begin @(posedge sys_clk); #1; end
         @(posedge sys_clk);
         s_axi_arvalid <= 1'b0;
         #1 while (s_axi_rvalid !== 1'b1) begin @(posedge sys_clk); #1; end
         @(posedge sys_clk);
         {rdv, resp} = {s_axi_rdata, s_axi_rresp};
         s_axi_rready <= 1'b0;
      end
   endtask
   task rc(input [4:0] a, input [31:0] e);
      begin
         rd(a);
         `CHK("read data", e, rdv)
      end
   endtask
   task tally_and_finish;
      begin
         $display("Comparisons %0d, mismatches %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      #200000 failures++;
      tally_and_finish;
   end
   // ***********************
   // Tests
   // ***********************
   initial begin
      {rst, vcoLock, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rc(CTL, 32'h20);
      rc(`OFS_BANDWIDTH_CONTROL, 32'h0);
      rc(`OFS_VCO_RANGE, 32'h40);
      rc(`OFS_REF_DIVIDER, 32'h1);
      rc(`OFS_MULTIPLIER, 32'h40);
      repeat (40) @(posedge sys_clk);
      `CHK("osc high", 8'h08, highLen)
      `CHK("osc low", 8'h08, lowLen)
      wr(CTL, 32'h2E);
      rc(CTL, 32'h20);
      wr(CTL, 32'h00);
      wr(CTL, 32'h0E);
      `CHK("prescaler", 2'h3, prescalerCode)
      `CHK("power range", 2'h2, vcoPowerCode)
      wr(`OFS_VCO_RANGE, 32'h0);
      wr(`OFS_REF_DIVIDER, 32'h0);
      wr(`OFS_MULTIPLIER, 32'h0);
      `CHK("ref divider", 4'h1, refDivEffective)
      `CHK("multiplier", 12'h001, multEffective)
      wr(CTL, 32'h1E);
      rc(CTL, 32'h0E);
      wr(CTL, 32'h3E);
      rc(CTL, 32'h2E);
      wr(CTL, 32'h3E);
      rc(CTL, 32'h2E);
      `CHK("power on", 1'b0, pllPowerOn)
      wr(CTL, 32'h0E);
      wr(`OFS_VCO_RANGE, 32'h40);
      wr(CTL, 32'h2E);
      wr(CTL, 32'h1E);
      rc(CTL, 32'h0E);
      wr(CTL, 32'h2E);
      wr(CTL, 32'h3E);
      rc(CTL, 32'h3E);
      repeat (200) @(posedge sys_clk);
      `CHK("vco high", 8'h0C, highLen)
      `CHK("vco low", 8'h0C, lowLen)
      wr(CTL, 32'h0E);
      rc(CTL, 32'h3E);
      wr(CTL, 32'hBE);
      rc(CTL, 32'h3E);
      vcoLock <= 1'b1;
      rc(CTL, 32'h3E);
      wr(`OFS_BANDWIDTH_CONTROL, 32'h1);
      rc(`OFS_BANDWIDTH_CONTROL, 32'h3);
      rc(CTL, 32'h7E);
      wr(CTL, 32'hBE);
      rc(CTL, 32'hBE);
      vcoLock <= 1'b0;
      repeat (4) @(posedge sys_clk);
      `CHK("interrupt set", 1'b1, pll_interrupt)
      rc(CTL, 32'hFE);
      `CHK("interrupt clear", 1'b0, pll_interrupt)
      rd(5'h14);
      `CHK("read refusal", `RESP_SLVERR, resp)
      wr(5'h18, 32'hFF);
      `CHK("write refusal", `RESP_SLVERR, resp)
      tally_and_finish;
   end
endmodule
